// file: cdc_measurement_sequencer_tb.sv
`timescale 1ns/1ps
module cdc_measurement_sequencer_tb;
    import cms_pkg::*;
    // ********
    // signals and monitor
    // ********
    localparam int LFD = 8;
    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic        psel   = 1'b0;
    logic        pen    = 1'b0;
    logic        pwr    = 1'b0;
    logic        fire   = 1'b0;
    logic        seen   = 1'b0;
    logic [1:0]  pin    = 2'h0;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, q;
    logic        pready, pslverr, cstart, eoc, int_n, busy, sw1, sw2, dcf, rreq, er;
    logic [3:0]  pins;
    logic [5:0]  ps;
    logic [7:0]  rec [0:1023];
    int          tcyc [0:1023];
    int          failures    = 0;
    int          comparisons = 0;
    int          now = 0;
    int          ncyc = 0;
    int          neoc = 0;

    cms_sequencer #(.LF_DIV(LFD)) dut_u (.MCLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .TRIG_PINS_I(pins), .PORT_SEL_O(ps), .PORT_SWITCH_FIRST_O(sw1),
        .PORT_SWITCH_SECOND_O(sw2), .PORT_DC_FREE_O(dcf), .CYCLE_START_O(cstart), .EOC_O(eoc),
        .INT_N_O(int_n), .BUSY_O(busy));
    cms_host_model host_u (.mclk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .pin_i(pin), .int_n_i(int_n),
        .pins_o(pins), .read_req_o(rreq));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        now  <= now + 1;
        seen <= (cstart === 1'b1);
        if (seen && ncyc < 1024) begin
            rec[ncyc] <= {ps, sw1, sw2};
            ncyc      <= ncyc + 1;
        end
        if (cstart === 1'b1 && ncyc < 1024) tcyc[ncyc] <= now;
        if (eoc === 1'b1) neoc <= neoc + 1;
        if (now == 90000) begin
            failures++;
            results;
        end
    end
    // ********
    // tasks and scenarios
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        e = pslverr;
        r = prdata;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, er);
    endtask
    task automatic wait_busy(input logic v, input int lim);
        int n;
        n = 0;
        while (busy !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, busy}, {31'h0, v});
    endtask
    task automatic wait_eoc(input int e);
        int n;
        n = 0;
        while (neoc == e && n < 20000) begin
            @(posedge clk);
            n++;
        end
        chk(32'(neoc - e), 32'h0000_0001);
    endtask
    task automatic stop;
        wr(ADDR_CTRL, 32'h0000_0006);
        wait_busy(1'b0, 20000);
    endtask
    task automatic t_cont;
        wait_busy(1'b1, 50);
        wait_eoc(0);
        chk(32'(ncyc), 32'h0000_0003);
        chk({26'h0, rec[0][7:2]}, 32'h0000_0001);
        chk({26'h0, rec[1][7:2]}, 32'h0000_0002);
        chk({24'h0, rec[2]}, 32'h0000_0000);
        repeat (20) @(posedge clk);
        chk({31'h0, busy}, 32'h0000_0000);
        wr(ADDR_CMD, 32'h0000_0001 << CMD_DONE_BIT);
        wait_busy(1'b1, 20);
        stop;
        $display("test continuous done");
    endtask
    task automatic t_regs;
        int b;
        apb(1'b0, ADDR_CTRL, 32'h0, q, er);
        chk(q, 32'h0000_0006);
        chk({31'h0, er}, 32'h0000_0000);
        apb(1'b0, ADDR_SEQ, 32'h0, q, er);
        chk(q, SEQ_RST);
        apb(1'b0, ADDR_CONV, 32'h0, q, er);
        chk(q, CONV_RST);
        apb(1'b0, 8'h1C, 32'h0, q, er);
        chk({31'h0, er}, 32'h0000_0001);
        wr(ADDR_GAIN, 32'h0000_0040);
        apb(1'b0, ADDR_GAIN, 32'h0, q, er);
        chk(q, 32'h0000_0040);
        wr(ADDR_CONV, 32'h0011_0001);
        b = ncyc;
        wr(ADDR_CMD, 32'h0000_0001);
        wait_eoc(neoc);
        chk(32'(ncyc - b), 32'h0000_0009);
        wr(ADDR_CONV, CONV_RST);
        $display("test registers done");
    endtask
    task automatic t_float;
        int b;
        int e;
        logic [31:0] c0;
        wr(ADDR_SEQ, 32'h0000_0705);
        chk({31'h0, dcf}, 32'h0000_0000);
        apb(1'b0, ADDR_COUNT, 32'h0, c0, er);
        b = ncyc;
        e = neoc;
        wr(ADDR_CMD, 32'h0000_0001);
        repeat (20) @(posedge clk);
        wr(ADDR_CMD, 32'h0000_0001);
        wait_eoc(e);
        chk(32'(ncyc - b), 32'h0000_0007);
        for (int i = 0; i < 6; i++) begin
            chk({30'h0, rec[b+i][1:0]}, (i % 3 == 0) ? 32'h2 : (i % 3 == 1) ? 32'h1 : 32'h3);
        end
        chk({24'h0, rec[b+6]}, 32'h0000_0000);
        apb(1'b0, ADDR_COUNT, 32'h0, q, er);
        chk(q, c0 + 32'h1);
        wr(ADDR_SEQ, 32'h0000_1B05);
        chk({31'h0, dcf}, 32'h0000_0001);
        wr(ADDR_SEQ, SEQ_RST);
        chk({31'h0, dcf}, 32'h0000_0000);
        $display("test floating done");
    endtask
    task automatic t_clock;
        logic [31:0] v [0:2];
        int x [0:2];
        int b;
        v = '{32'h0000_0006, 32'h0000_0016, 32'h0000_0036};
        x = '{LFD, HF_DIV * HF_CYCLES, HF_CYCLES};
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL, v[i]);
            b = ncyc;
            wr(ADDR_CMD, 32'h0000_0001);
            wait_eoc(neoc);
            chk(32'(tcyc[b+1] - tcyc[b]), 32'(x[i]));
        end
        stop;
        $display("test cycle clock done");
    endtask
    task automatic t_read;
        int n;
        wr(ADDR_CTRL, 32'h0000_0001);
        wr(ADDR_CMD, 32'h0000_0001);
        wait_eoc(neoc);
        repeat (3) @(posedge clk);
        chk({31'h0, int_n}, 32'h0000_0000);
        n = 0;
        while (rreq !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, busy}, 32'h0000_0000);
        apb(1'b0, ADDR_STATUS, 32'h0, q, er);
        wr(ADDR_CMD, 32'h0000_0001 << CMD_READ_BIT);
        wait_busy(1'b1, 20);
        chk({31'h0, int_n}, 32'h0000_0001);
        stop;
        $display("test read triggered done");
    endtask
    task automatic t_pin;
        wr(ADDR_CTRL, 32'h0000_0205);
        pin  <= 2'h1;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (20) @(posedge clk);
        chk({31'h0, busy}, 32'h0000_0000);
        pin  <= 2'h2;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        wait_busy(1'b1, 20);
        stop;
        $display("test pin triggered done");
    endtask
    task automatic t_timer;
        for (int m = 2; m < 4; m++) begin
            wr(ADDR_CTRL, 32'(m));
            wait_busy(1'b1, 20000);
            stop;
        end
        $display("test timer done");
    endtask
    task automatic results;
        $display("counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_cont;
        t_regs;
        t_float;
        t_clock;
        t_read;
        t_pin;
        t_timer;
        results;
    end
endmodule // cdc_measurement_sequencer_tb

// file: cms_cycle_clk.sv
`timescale 1ns/1ps
module cms_cycle_clk
    import cms_pkg::*;
#(
    parameter int LF_DIV = LF_CYCLES
) (
    // clock and reset
    input  wire logic MCLK_I,
    input  wire logic RESET_N_I,
    // control and tick
    cms_tick_if.gen   tk
);
    logic [31:0] hf_cnt_r, hf_cnt_nxt;
    logic [31:0] lf_cnt_r, lf_cnt_nxt;
    logic [1:0]  q_r, q_nxt;
    logic        hf_p, lf_p;
    // ************************************************************
    // oscillator dividers and quarter divider
    // ************************************************************
    always_comb begin
        hf_p       = (hf_cnt_r == 32'(HF_CYCLES - 1));
        lf_p       = (lf_cnt_r == 32'(LF_DIV - 1));
        hf_cnt_nxt = hf_p ? 32'h0000_0000 : hf_cnt_r + 32'h0000_0001;
        lf_cnt_nxt = lf_p ? 32'h0000_0000 : lf_cnt_r + 32'h0000_0001;
        q_nxt      = hf_p ? q_r + 2'h1 : q_r;
        if (!tk.hf_sel) begin
            tk.tick = lf_p;
        end else if (tk.div4_dis) begin
            tk.tick = hf_p;
        end else begin
            tk.tick = hf_p && (q_r == 2'(HF_DIV - 1));
        end
    end
    always_ff @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
            hf_cnt_r <= 32'h0000_0000;
            lf_cnt_r <= 32'h0000_0000;
            q_r      <= 2'h0;
        end else begin
            hf_cnt_r <= hf_cnt_nxt;
            lf_cnt_r <= lf_cnt_nxt;
            q_r      <= q_nxt;
        end
    end
endmodule // cms_cycle_clk

// file: cms_host_model.sv
`timescale 1ns/1ps
// ********
// host model: trigger pins, read on interrupt
// ********
module cms_host_model (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // requests from bench
    input  wire logic       fire_i,
    input  wire logic [1:0] pin_i,
    // device side
    input  wire logic       int_n_i,
    output logic      [3:0] pins_o,
    output logic            read_req_o
);
    logic [2:0] hold_r;
    logic       int_n_d_r;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pins_o     <= 4'h0;
            hold_r     <= 3'h0;
            int_n_d_r  <= 1'b1;
            read_req_o <= 1'b0;
        end else begin
            int_n_d_r <= int_n_i;
            if (fire_i) begin
                pins_o <= 4'h1 << pin_i;
                hold_r <= 3'h4;
            end else if (hold_r != 3'h0) begin
                hold_r <= hold_r - 3'h1;
                pins_o <= (hold_r == 3'h1) ? 4'h0 : pins_o;
            end
            if (int_n_d_r && !int_n_i) read_req_o <= 1'b1;
            else if (int_n_i) read_req_o <= 1'b0;
        end
    end
endmodule // cms_host_model

// file: cms_pkg.sv
package cms_pkg;
    // ************************************************************
    // apb register map
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_SEQ    = 8'h04;
    localparam logic [7:0] ADDR_CONV   = 8'h08;
    localparam logic [7:0] ADDR_CMD    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_GAIN   = 8'h14;
    localparam logic [7:0] ADDR_COUNT  = 8'h18;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_TRIG_LSB  = 0;
    localparam int CTRL_HF_BIT    = 4;
    localparam int CTRL_DIV4_BIT  = 5;
    localparam int CTRL_PIN_LSB   = 8;
    localparam int SEQ_PORT_LSB   = 0;
    localparam int SEQ_FLOAT_BIT  = 8;
    localparam int SEQ_CINT_BIT   = 9;
    localparam int SEQ_CEXT_BIT   = 10;
    localparam int SEQ_DCBAL_BIT  = 11;
    localparam int SEQ_DIFF_BIT   = 12;
    localparam int CONV_AVG_LSB   = 0;
    localparam int CONV_DUMMY_LSB = 16;
    localparam int CONV_TMR_LSB   = 20;
    localparam int CMD_START_BIT  = 0;
    localparam int CMD_READ_BIT   = 1;
    localparam int CMD_DONE_BIT   = 2;
    localparam int CMD_EOC_BIT    = 3;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] SEQ_RST   = 32'h0000_0203;
    localparam logic [31:0] CONV_RST  = 32'h0010_0000;
    localparam logic [31:0] GAIN_RST  = 32'h0000_0000;
    // ************************************************************
    // sizes and timing
    // ************************************************************
    localparam int NUM_PORTS  = 6;
    localparam int AVG_W      = 13;
    localparam int DUMMY_W    = 4;
    localparam int TMR_W      = 12;
    localparam int HF_DIV     = 4;
    localparam int MCLK_MHZ   = 100;
    localparam int HF_MHZ     = 2;
    localparam int HF_CYCLES  = MCLK_MHZ / HF_MHZ;
    localparam int LF_KHZ     = 50;
    localparam int LF_CYCLES  = MCLK_MHZ * 1000 / LF_KHZ;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        TRIG_CONT    = 3'h0,
        TRIG_READ    = 3'h1,
        TRIG_TIMER   = 3'h2,
        TRIG_TIMER_S = 3'h3,
        TRIG_UNDEF   = 3'h4,
        TRIG_PIN     = 3'h5,
        TRIG_OPCODE  = 3'h6,
        TRIG_CONT_X  = 3'h7
    } cms_trig_e;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REF,
        ST_PORT,
        ST_CINT,
        ST_DONE
    } cms_state_e;
endpackage

// file: cms_sequencer.sv
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - grounded: reference port then enabled sensor ports
// - internal compensation closes sequence, ports off
// - floating: reference pair then one-two pairs
// - external compensation: first, second, both ports
// - floating sequence ends with stray cycle
// - conversion runs to completion once triggered
// - end-of-conversion flag to processor and converter
// - continuous starts after reset and after processing
// - read mode drives interrupt low at end
// - end of serial read starts next conversion
// - timer mode uses internal timer
// - stray cycle opens both port switches
// - charge first, second, then both electrodes
// - dc balance option changes port drive
// - cycle base slow, four fast, or fast
// - quarter divider disable picks 2 or 0.5 MHz
// - trigger source encoding as listed
// - dummy cycles then averaged samples
module cms_sequencer
    import cms_pkg::*;
#(
    parameter int LF_DIV = LF_CYCLES
) (
    // clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        RESET_N_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // trigger pins
    input  wire logic [3:0]  TRIG_PINS_I,
    // port drive
    output logic      [5:0]  PORT_SEL_O,
    output logic             PORT_SWITCH_FIRST_O,
    output logic             PORT_SWITCH_SECOND_O,
    output logic             PORT_DC_FREE_O,
    output logic             CYCLE_START_O,
    // status
    output logic             EOC_O,
    output logic             INT_N_O,
    output logic             BUSY_O
);
    import cms_pkg::*;
    cms_tick_if tk ();
    logic [31:0] ctrl_r, ctrl_nxt, seq_r, seq_nxt, conv_r, conv_nxt, gain_r, gain_nxt;
    logic [15:0] count_r, count_nxt;
    cms_state_e  st_r, st_nxt;
    logic [2:0]  idx_r, idx_nxt;
    logic [1:0]  sub_r, sub_nxt;
    logic [AVG_W:0] smp_r, smp_nxt;
    logic [DUMMY_W:0] dum_r, dum_nxt;
    logic [TMR_W-1:0] tmr_r, tmr_nxt;
    logic        boot_r, boot_nxt, int_n_r, int_n_nxt, eoc_r, eoc_nxt;
    logic [5:0]  sel_r, sel_nxt;
    logic        sw1_r, sw1_nxt, sw2_r, sw2_nxt, cs_r, cs_nxt;
    logic        wr, rd, start_req, flo, step, pin_v, pin_r;
    cms_trig_e   trig;
    logic [31:0] rdata;
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic port_on(input logic [31:0] s, input logic [2:0] i);
        port_on = s[SEQ_PORT_LSB + int'(i)];
    endfunction
    function automatic logic [2:0] next_port(input logic [31:0] s, input logic [2:0] i, input logic f);
        logic [2:0] n;
        n = 3'h7;
        for (int k = NUM_PORTS - 1; k > 0; k--) begin
            if (3'(k) > i && port_on(s, 3'(k)) && (!f || k[0] == 1'b0)) begin
                n = 3'(k);
            end
        end
        next_port = n;
    endfunction
    cms_cycle_clk #(.LF_DIV(LF_DIV)) u_clk (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .tk(tk.gen));
    assign tk.hf_sel   = ctrl_r[CTRL_HF_BIT];
    assign tk.div4_dis = ctrl_r[CTRL_DIV4_BIT];
    assign step        = tk.tick;
    assign flo         = seq_r[SEQ_FLOAT_BIT];
    assign trig        = cms_trig_e'(ctrl_r[CTRL_TRIG_LSB +: 3]);
    // ************************************************************
    // apb registers
    // ************************************************************
    assign wr        = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd        = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign PREADY_O  = 1'b1;
    assign pin_v     = TRIG_PINS_I[ctrl_r[CTRL_PIN_LSB +: 2]];
    always_comb begin
        ctrl_nxt = ctrl_r;
        seq_nxt  = seq_r;
        conv_nxt = conv_r;
        gain_nxt = gain_r;
        rdata    = 32'h0000_0000;
        if (wr && PADDR_I == ADDR_CTRL) begin
            ctrl_nxt = PWDATA_I;
        end else if (wr && PADDR_I == ADDR_SEQ) begin
            seq_nxt = PWDATA_I;
        end else if (wr && PADDR_I == ADDR_CONV) begin
            conv_nxt = PWDATA_I;
        end else if (wr && PADDR_I == ADDR_GAIN) begin
            gain_nxt = PWDATA_I;
        end
        if (PADDR_I == ADDR_CTRL) begin
            rdata = ctrl_r;
        end else if (PADDR_I == ADDR_SEQ) begin
            rdata = seq_r;
        end else if (PADDR_I == ADDR_CONV) begin
            rdata = conv_r;
        end else if (PADDR_I == ADDR_STATUS) begin
            rdata = {27'h000_0000, int_n_r, eoc_r, st_r};
        end else if (PADDR_I == ADDR_GAIN) begin
            rdata = gain_r;
        end else if (PADDR_I == ADDR_COUNT) begin
            rdata = {16'h0000, count_r};
        end
    end
    assign PSLVERR_O = PSEL_I && PENABLE_I && !(PADDR_I == ADDR_CTRL || PADDR_I == ADDR_SEQ
        || PADDR_I == ADDR_CONV || PADDR_I == ADDR_CMD || PADDR_I == ADDR_STATUS
        || PADDR_I == ADDR_GAIN || PADDR_I == ADDR_COUNT);
    // ************************************************************
    // trigger selection
    // ************************************************************
    always_comb begin
        start_req = 1'b0;
        tmr_nxt   = tmr_r;
        case (trig)
            TRIG_CONT, TRIG_CONT_X: begin
                start_req = boot_r || (wr && PADDR_I == ADDR_CMD && PWDATA_I[CMD_DONE_BIT]);
            end
            TRIG_READ: begin
                start_req = wr && PADDR_I == ADDR_CMD
                    && (PWDATA_I[CMD_START_BIT] || PWDATA_I[CMD_READ_BIT]);
            end
            TRIG_TIMER, TRIG_TIMER_S: begin
                if (step) begin
                    tmr_nxt = (tmr_r == 0) ? conv_r[CONV_TMR_LSB +: TMR_W] : tmr_r - 1'b1;
                end
                start_req = step && tmr_r == 0;
            end
            TRIG_PIN: begin
                start_req = pin_v && !pin_r;
            end
            TRIG_OPCODE: begin
                start_req = wr && PADDR_I == ADDR_CMD && PWDATA_I[CMD_START_BIT];
            end
            default: begin
                start_req = 1'b0;
            end
        endcase
    end
    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        st_nxt    = st_r;
        idx_nxt   = idx_r;
        sub_nxt   = sub_r;
        smp_nxt   = smp_r;
        dum_nxt   = dum_r;
        boot_nxt  = 1'b0;
        eoc_nxt   = 1'b0;
        int_n_nxt = int_n_r;
        count_nxt = count_r;
        sel_nxt   = sel_r;
        sw1_nxt   = sw1_r;
        sw2_nxt   = sw2_r;
        cs_nxt    = 1'b0;
        if (wr && PADDR_I == ADDR_CMD && PWDATA_I[CMD_READ_BIT]) begin
            int_n_nxt = 1'b1;
        end
        case (st_r)
            ST_IDLE: begin
                if (start_req) begin
                    st_nxt  = ST_REF;
                    idx_nxt = 3'h0;
                    sub_nxt = 2'h0;
                    smp_nxt = '0;
                    dum_nxt = '0;
                end
            end
            ST_REF, ST_PORT: begin
                if (step) begin
                    cs_nxt = 1'b1;
                    sel_nxt = '0;
                    if (flo) begin
                        sel_nxt[idx_r]      = (sub_r != 2'h1);
                        sel_nxt[idx_r + 1'b1] = (sub_r != 2'h0);
                        sw1_nxt = (sub_r != 2'h1);
                        sw2_nxt = (sub_r != 2'h0) || seq_r[SEQ_DCBAL_BIT];
                    end else begin
                        sel_nxt[idx_r] = 1'b1;
                        sw1_nxt = 1'b1;
                        sw2_nxt = 1'b0;
                    end
                    if (flo && seq_r[SEQ_CEXT_BIT] && sub_r != 2'h2) begin
                        sub_nxt = sub_r + 2'h1;
                    end else if (flo && !seq_r[SEQ_CEXT_BIT] && sub_r == 2'h0) begin
                        sub_nxt = 2'h1;
                    end else begin
                        sub_nxt = 2'h0;
                        idx_nxt = next_port(seq_r, idx_r + (flo ? 3'h1 : 3'h0), flo);
                        st_nxt  = (next_port(seq_r, idx_r + (flo ? 3'h1 : 3'h0), flo) == 3'h7)
                            ? (seq_r[SEQ_CINT_BIT] || flo ? ST_CINT : ST_DONE) : ST_PORT;
                    end
                end
            end
            ST_CINT: begin
                if (step) begin
                    cs_nxt  = 1'b1;
                    sel_nxt = '0;
                    sw1_nxt = 1'b0;
                    sw2_nxt = 1'b0;
                    st_nxt  = ST_DONE;
                end
            end
            ST_DONE: begin
                if (dum_r < {1'b0, conv_r[CONV_DUMMY_LSB +: DUMMY_W]}) begin
                    dum_nxt = dum_r + 1'b1;
                    st_nxt  = ST_REF;
                    idx_nxt = 3'h0;
                end else if (smp_r < {1'b0, conv_r[CONV_AVG_LSB +: AVG_W]}) begin
                    smp_nxt = smp_r + 1'b1;
                    st_nxt  = ST_REF;
                    idx_nxt = 3'h0;
                end else begin
                    st_nxt    = ST_IDLE;
                    eoc_nxt   = 1'b1;
                    count_nxt = count_r + 16'h0001;
                    if (trig == TRIG_READ) begin
                        int_n_nxt = 1'b0;
                    end
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end
    always_ff @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
            ctrl_r  <= CTRL_RST;
            seq_r   <= SEQ_RST;
            conv_r  <= CONV_RST;
            gain_r  <= GAIN_RST;
            count_r <= 16'h0000;
            st_r    <= ST_IDLE;
            idx_r   <= 3'h0;
            sub_r   <= 2'h0;
            smp_r   <= '0;
            dum_r   <= '0;
            tmr_r   <= '0;
            boot_r  <= 1'b1;
            int_n_r <= 1'b1;
            eoc_r   <= 1'b0;
            sel_r   <= 6'h00;
            sw1_r   <= 1'b0;
            sw2_r   <= 1'b0;
            cs_r    <= 1'b0;
            pin_r   <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
        end else begin
            ctrl_r  <= ctrl_nxt;
            seq_r   <= seq_nxt;
            conv_r  <= conv_nxt;
            gain_r  <= gain_nxt;
            count_r <= count_nxt;
            st_r    <= st_nxt;
            idx_r   <= idx_nxt;
            sub_r   <= sub_nxt;
            smp_r   <= smp_nxt;
            dum_r   <= dum_nxt;
            tmr_r   <= tmr_nxt;
            boot_r  <= boot_nxt;
            int_n_r <= int_n_nxt;
            eoc_r   <= eoc_nxt;
            sel_r   <= sel_nxt;
            sw1_r   <= sw1_nxt;
            sw2_r   <= sw2_nxt;
            cs_r    <= cs_nxt;
            pin_r   <= pin_v;
            PRDATA_O <= rd ? rdata : PRDATA_O;
        end
    end
    assign PORT_SEL_O           = sel_r;
    assign PORT_SWITCH_FIRST_O  = sw1_r;
    assign PORT_SWITCH_SECOND_O = sw2_r;
    assign PORT_DC_FREE_O       = flo && seq_r[SEQ_DIFF_BIT] && seq_r[SEQ_DCBAL_BIT];
    assign CYCLE_START_O        = cs_r;
    assign EOC_O                = eoc_r;
    assign INT_N_O              = int_n_r;
    assign BUSY_O               = (st_r != ST_IDLE);
    // ************************************************************
    // assertions
    // ************************************************************
    eoc_pulse_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) EOC_O |=> !EOC_O)
        else $error("eoc longer than one cycle");
    no_restart_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        (st_r == ST_PORT && !step) |=> st_r == ST_PORT)
        else $error("conversion restarted");
    cint_open_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        (st_r == ST_CINT && step) |=> (!sw1_r && !sw2_r && sel_r == 6'h00))
        else $error("switch closed in stray cycle");
    int_low_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        (EOC_O && trig == TRIG_READ) |-> !INT_N_O)
        else $error("interrupt not low");
    eoc_idle_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) EOC_O |-> st_r == ST_IDLE)
        else $error("eoc while busy");
    ref_first_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        (st_r == ST_IDLE && start_req) |=> st_r == ST_REF && idx_r == 3'h0)
        else $error("sequence not from reference");
    flo_cint_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        (flo && st_r == ST_PORT && step && st_nxt == ST_DONE) |-> 1'b0)
        else $error("floating without stray cycle");
    undef_trig_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        (trig == TRIG_UNDEF) |-> !start_req)
        else $error("undefined trigger started");
    cov_eoc_c: cover property (@(posedge MCLK_I) EOC_O);
    cov_cint_c: cover property (@(posedge MCLK_I) st_r == ST_CINT);
    cov_read_c: cover property (@(posedge MCLK_I) trig == TRIG_READ && !INT_N_O);
endmodule // cms_sequencer

// file: cms_tick_if.sv
`timescale 1ns/1ps
interface cms_tick_if;
    logic hf_sel;
    logic div4_dis;
    logic tick;
    modport gen (input hf_sel, input div4_dis, output tick);
    modport use_m (output hf_sel, output div4_dis, input tick);
endinterface
